// ==== rtl/printer_port_fifo_control.sv ====
// printer port control: extra functions, fifo level, direction select, reset states
// Contract
// RL1 - extra-function fifo enable resets to 0; writing 1 enables the 83-byte fifo
// RL2 - timing field picks strobe delay/width 3/2 5/4 5/4 9/8 6/4 10/8 10/8 18/16
// RL3 - top timing bit 0 picks first four pairs, 1 picks last four, same order
// RL4 - handshake source bit: 0 uses acknowledge, 1 uses busy for draining and interrupt; code switches draining only, interrupt stays on acknowledge
// RL5 - irq type 00 normal, 01/11 empty, 10 full; status bits 0 and 6 follow
// RL6 - polarity bit 1 inverts interrupt output; 0 follows acknowledge normally
// RL7 - fifo level register bits 0 to 6 give bytes still queued
// RL8 - fifo level bit 7 reads 0 when fifo enabled, 1 when disabled
// RL9 - mode pin high: control bit 5 sets direction, direction register ignored
// RL10 - mode pin low: writing AA selects input, 55 output; control bit 5 ignored
// RL11 - direction select register is write only, never read back
// RL12 - reset drives data low as outputs, strobe autofeed select-in high, init low
// RL13 - one byte leaves the fifo per falling edge of the chosen handshake
// RL14 - in fifo mode strobe is automatic; strobe control bit writes do nothing
// RL15 - a byte written while the fifo is full is dropped, count unchanged
`include "printer_port_defines.svh"
module printer_port_fifo_control
   import printer_port_pkg::*;
#(
   parameter int DEPTH = `FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic clkEn,
   input wire reg_req_t regReq,
   output logic [7:0] regRdData,
   input wire printer_in_t printerIn,
   input wire logic bidirPinMode,
   input wire logic [7:0] portDataIn,
   output logic [7:0] portDataOut,
   output logic [7:0] portDataOe,
   output logic strobe_n,
   output logic autoLinefeed_n,
   output logic initOut,
   output logic printerSelectIn_n,
   output logic printerIrq_n,
   output logic printerIrqOe
);
   localparam int CW = $clog2(DEPTH + 1);

   logic [5:0] ctrl_q;
   logic [7:0] extra_q;
   logic dirIn_q;
   logic [7:0] dataOut_q;
   logic [7:0] rdData_q;
   logic hsPrev_q;
   logic ackPrev_q;
   logic irqPend_q;
   drain_state_t state_q;

   logic fifoEn;
   logic portIn;
   logic hs;
   logic hsFall;
   logic ackFall;
   logic wrPort;
   logic wrDir;
   logic wrCtrl;
   logic wrExtra;
   logic rdStatus;
   logic flush;
   logic fifoInReady;
   logic fifoOutValid;
   logic popFire;
   logic [7:0] fifoHead;
   logic [CW-1:0] fifoLevel;
   logic fifoFull;
   logic fifoEmpty;
   logic timerStart;
   logic timerStrobe;
   logic timerDone;
   logic irqRaw;
   logic [1:0] irqType;
   logic [7:0] statusByte;
   logic [7:0] commandByte;
   logic [7:0] levelByte;
   logic [7:0] rdNext;

   function automatic strobe_timing_t decodeTiming(input logic [2:0] sel);
      strobe_timing_t t;
      t = '0;
      case (sel[1:0]) // RL3
         2'h0: t = '{delay: 5'h03, width: 5'h02};
         2'h1: t = '{delay: 5'h05, width: 5'h04};
         2'h2: t = '{delay: 5'h05, width: 5'h04};
         default: t = '{delay: 5'h09, width: 5'h08};
      endcase
      if (sel[`EXTRA_TIMING_HI]) begin // RL3
         if (sel[1:0] == 2'h0) begin
            t = '{delay: 5'h06, width: 5'h04};
         end else begin
            t.delay = 5'(t.delay * 2);
            t.width = 5'(t.width * 2);
         end
      end
      return t;
   endfunction : decodeTiming

   function automatic logic isWrite(input reg_req_t r, input logic [1:0] ofs);
      return r.wr && (r.addr == ofs);
   endfunction : isWrite

   assign wrPort = clkEn && isWrite(regReq, `OFS_PORT);
   assign wrDir = clkEn && isWrite(regReq, `OFS_DIR_STATUS);
   assign wrCtrl = clkEn && isWrite(regReq, `OFS_CTRL_CMD);
   assign wrExtra = clkEn && isWrite(regReq, `OFS_EXTRA_LEVEL);
   assign rdStatus = clkEn && regReq.rd && (regReq.addr == `OFS_DIR_STATUS);

   assign fifoEn = extra_q[`EXTRA_FIFO_EN]; // RL1
   assign irqType = extra_q[`EXTRA_TYPE_HI:`EXTRA_TYPE_LO];
   assign hs = extra_q[`EXTRA_HS_SRC] ? printerIn.busy : printerIn.ack_n; // RL4
   assign hsFall = hsPrev_q && !hs; // RL13
   assign ackFall = ackPrev_q && !printerIn.ack_n;
   // a change of the init line empties the queue
   assign flush = wrCtrl && (regReq.wrData[`CTRL_INIT] != ctrl_q[`CTRL_INIT]);
   assign fifoFull = !fifoInReady;
   assign fifoEmpty = !fifoOutValid;

   byte_fifo #(
      .WIDTH(8),
      .DEPTH(DEPTH),
      .CW(CW)
   ) u_fifo (
      .clk(clk),
      .rst_b(rst_b),
      .clkEn(clkEn),
      .flush(flush),
      .inValid(wrPort && fifoEn), // RL15
      .inReady(fifoInReady),
      .inData(regReq.wrData),
      .outValid(fifoOutValid),
      .outReady(popFire),
      .outData(fifoHead),
      .level(fifoLevel)
   );

   strobe_timer u_timer (
      .clk(clk),
      .rst_b(rst_b),
      .clkEn(clkEn),
      .start(timerStart),
      .timing(decodeTiming(extra_q[2:0])), // RL2
      .strobeAct(timerStrobe),
      .done(timerDone)
   );

   assign timerStart = (state_q == DRAIN_IDLE) && fifoEn && fifoOutValid && !flush;
   assign popFire = clkEn && (state_q == DRAIN_WAIT) && hsFall && !flush; // RL13

   // drain sequencer: strobe the head byte, then wait for the printer's edge
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state_q <= DRAIN_IDLE;
      end else if (clkEn) begin
         if (flush || !fifoEn) begin
            state_q <= DRAIN_IDLE;
         end else begin
            case (state_q)
               DRAIN_IDLE: begin
                  if (timerStart) begin
                     state_q <= DRAIN_STROBE;
                  end
               end
               DRAIN_STROBE: begin
                  if (timerDone) begin
                     state_q <= DRAIN_WAIT;
                  end
               end
               DRAIN_WAIT: begin
                  if (hsFall) begin
                     state_q <= DRAIN_IDLE;
                  end
               end
               default: state_q <= DRAIN_IDLE;
            endcase
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         hsPrev_q <= 1'b1;
         ackPrev_q <= 1'b1;
      end else if (clkEn) begin
         hsPrev_q <= hs;
         ackPrev_q <= printerIn.ack_n;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         ctrl_q <= `CTRL_RESET; // RL12
      end else if (wrCtrl) begin
         ctrl_q <= regReq.wrData[5:0];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         extra_q <= `EXTRA_RESET; // RL1
      end else if (wrExtra) begin
         extra_q <= regReq.wrData;
      end
   end

   // direction codes only count while the mode pin is low
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         dirIn_q <= 1'b0;
      end else if (wrDir && !bidirPinMode) begin
         if (regReq.wrData == `DIR_IN_CODE) begin // RL10
            dirIn_q <= 1'b1;
         end else if (regReq.wrData == `DIR_OUT_CODE) begin // RL10
            dirIn_q <= 1'b0;
         end
      end
   end

   assign portIn = bidirPinMode ? ctrl_q[`CTRL_DIR] : dirIn_q; // RL9 RL10
   assign portDataOe = {8{!portIn}};

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         dataOut_q <= `DATA_RESET; // RL12
      end else if (clkEn) begin
         if (timerStart) begin
            dataOut_q <= fifoHead;
         end else if (wrPort && !fifoEn) begin
            dataOut_q <= regReq.wrData;
         end
      end
   end
   assign portDataOut = dataOut_q;

   assign strobe_n = fifoEn ? !timerStrobe : !ctrl_q[`CTRL_STROBE]; // RL14
   assign autoLinefeed_n = !ctrl_q[`CTRL_AUTOFEED]; // RL12
   assign initOut = ctrl_q[`CTRL_INIT]; // RL12
   assign printerSelectIn_n = !ctrl_q[`CTRL_SELIN]; // RL12

   // latched pending flag: an edge in the reading cycle wins
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         irqPend_q <= 1'b0;
      end else if (clkEn) begin
         if (ackFall) begin
            irqPend_q <= 1'b1;
         end else if (rdStatus) begin
            irqPend_q <= 1'b0;
         end
      end
   end

   always_comb begin
      case (irqType) // RL5
         `IRQ_TYPE_NORMAL: irqRaw = printerIn.ack_n;
         `IRQ_TYPE_FULL: irqRaw = !fifoFull;
         default: irqRaw = !fifoEmpty;
      endcase
   end
   assign printerIrq_n = irqRaw ^ extra_q[`EXTRA_POLARITY]; // RL6
   assign printerIrqOe = ctrl_q[`CTRL_IRQ_OE];

   always_comb begin
      statusByte = 8'h00;
      statusByte[0] = (irqType != `IRQ_TYPE_EMPTY_LO); // RL5
      statusByte[1] = 1'b1;
      statusByte[2] = !irqPend_q;
      statusByte[3] = printerIn.fault;
      statusByte[4] = printerIn.online;
      statusByte[5] = printerIn.paperOut;
      case (irqType) // RL5
         `IRQ_TYPE_NORMAL: statusByte[6] = !printerIn.busy;
         `IRQ_TYPE_FULL: statusByte[6] = fifoFull;
         default: statusByte[6] = fifoEmpty;
      endcase
      statusByte[7] = fifoEn ? !fifoFull : !printerIn.busy;
   end

   assign commandByte = {3'h7, ctrl_q[`CTRL_IRQ_OE], !printerSelectIn_n, initOut,
                         !autoLinefeed_n, !strobe_n};
   assign levelByte = {!fifoEn, 7'(fifoLevel)}; // RL7 RL8

   always_comb begin
      case (regReq.addr)
         `OFS_PORT: rdNext = portIn ? portDataIn : dataOut_q;
         `OFS_DIR_STATUS: rdNext = statusByte; // RL11
         `OFS_CTRL_CMD: rdNext = commandByte;
         default: rdNext = levelByte;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         rdData_q <= 8'h00;
      end else if (clkEn && regReq.rd) begin
         rdData_q <= rdNext;
      end
   end
   assign regRdData = rdData_q;

   property p_reset_fifo_off;
      @(posedge clk) !rst_b |=> !fifoEn;
   endproperty
   a_reset_fifo_off: assert property (p_reset_fifo_off) else $error("fifo on after reset"); // RL1

   property p_reset_lines;
      @(posedge clk) !rst_b |=> (strobe_n && autoLinefeed_n && printerSelectIn_n && !initOut
                                  && portDataOe == 8'hFF && portDataOut == 8'h00);
   endproperty
   a_reset_lines: assert property (p_reset_lines) else $error("bad reset line state"); // RL12

   property p_level_read;
      @(posedge clk) disable iff (!rst_b)
      (clkEn && regReq.rd && regReq.addr == `OFS_EXTRA_LEVEL) |=>
         (regRdData == {!$past(fifoEn), 7'($past(fifoLevel))});
   endproperty
   a_level_read: assert property (p_level_read) else $error("level read wrong"); // RL7 RL8

   property p_status_bit0;
      @(posedge clk) disable iff (!rst_b)
      (clkEn && regReq.rd && regReq.addr == `OFS_DIR_STATUS) |=>
         (regRdData[0] == ($past(irqType) != `IRQ_TYPE_EMPTY_LO));
   endproperty
   a_status_bit0: assert property (p_status_bit0) else $error("status bit 0 wrong"); // RL5

   property p_polarity;
      @(posedge clk) disable iff (!rst_b)
      (irqType == `IRQ_TYPE_NORMAL) |-> (printerIrq_n == (printerIn.ack_n ^ extra_q[6]));
   endproperty
   a_polarity: assert property (p_polarity) else $error("irq polarity wrong"); // RL6

   property p_pop_on_edge;
      @(posedge clk) disable iff (!rst_b)
      popFire |-> ($past(extra_q[3] ? printerIn.busy : printerIn.ack_n)
                   && !(extra_q[3] ? printerIn.busy : printerIn.ack_n));
   endproperty
   a_pop_on_edge: assert property (p_pop_on_edge) else $error("pop without edge"); // RL13 RL4

   property p_auto_strobe;
      @(posedge clk) disable iff (!rst_b)
      (clkEn && fifoEn && state_q == DRAIN_IDLE && !fifoOutValid) ##1 fifoEn |-> strobe_n;
   endproperty
   a_auto_strobe: assert property (p_auto_strobe) else $error("strobe not automatic"); // RL14

   sequence s_ctrl_dir_write;
      clkEn && bidirPinMode && wrCtrl;
   endsequence
   property p_pin_dir;
      @(posedge clk) disable iff (!rst_b)
      s_ctrl_dir_write ##1 bidirPinMode |-> (portDataOe == {8{!$past(regReq.wrData[5])}});
   endproperty
   a_pin_dir: assert property (p_pin_dir) else $error("pin mode direction wrong"); // RL9

   property p_code_dir;
      @(posedge clk) disable iff (!rst_b)
      (wrDir && !bidirPinMode && regReq.wrData == `DIR_IN_CODE) ##1 !bidirPinMode
         |-> (portDataOe == 8'h00);
   endproperty
   a_code_dir: assert property (p_code_dir) else $error("code direction wrong"); // RL10
endmodule : printer_port_fifo_control

// ==== rtl/printer_port_defines.svh ====
// register offsets, field positions, reset values and counts of the printer port
`ifndef PRINTER_PORT_DEFINES_SVH
`define PRINTER_PORT_DEFINES_SVH
`define OFS_PORT 2'h0
`define OFS_DIR_STATUS 2'h1
`define OFS_CTRL_CMD 2'h2
`define OFS_EXTRA_LEVEL 2'h3
`define CTRL_STROBE 0
`define CTRL_AUTOFEED 1
`define CTRL_INIT 2
`define CTRL_SELIN 3
`define CTRL_IRQ_OE 4
`define CTRL_DIR 5
`define EXTRA_TIMING_HI 2
`define EXTRA_HS_SRC 3
`define EXTRA_TYPE_LO 4
`define EXTRA_TYPE_HI 5
`define EXTRA_POLARITY 6
`define EXTRA_FIFO_EN 7
`define CTRL_RESET 6'h00
`define EXTRA_RESET 8'h00
`define DATA_RESET 8'h00
`define DIR_IN_CODE 8'hAA
`define DIR_OUT_CODE 8'h55
`define IRQ_TYPE_NORMAL 2'h0
`define IRQ_TYPE_EMPTY 2'h1
`define IRQ_TYPE_FULL 2'h2
`define IRQ_TYPE_EMPTY_LO 2'h3
`define FIFO_DEPTH 83
`define FIFO_WIDTH 8
`endif

// ==== rtl/printer_port_pkg.sv ====
// types shared by the printer port modules
package printer_port_pkg;
   typedef enum logic [2:0] {
      DRAIN_IDLE = 3'h1,
      DRAIN_STROBE = 3'h2,
      DRAIN_WAIT = 3'h4
   } drain_state_t;
   typedef struct packed {
      logic [4:0] delay;
      logic [4:0] width;
   } strobe_timing_t;
   typedef struct packed {
      logic ack_n;
      logic busy;
      logic fault;
      logic online;
      logic paperOut;
   } printer_in_t;
   typedef struct packed {
      logic [1:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wrData;
   } reg_req_t;
endpackage : printer_port_pkg

// ==== rtl/byte_fifo.sv ====
// transmit fifo with valid/ready on both sides and a level count
`include "printer_port_defines.svh"
module byte_fifo
   import printer_port_pkg::*;
#(
   parameter int WIDTH = `FIFO_WIDTH,
   parameter int DEPTH = `FIFO_DEPTH,
   parameter int CW = $clog2(DEPTH + 1)
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic clkEn,
   input wire logic flush,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData,
   output logic [CW-1:0] level
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wrPtr_q;
   logic [PW-1:0] rdPtr_q;
   logic [CW-1:0] level_q;
   logic push;
   logic pop;

   function automatic logic [PW-1:0] advance(input logic [PW-1:0] p);
      advance = (p == LAST) ? '0 : p + 1'b1;
   endfunction : advance

   assign inReady = (level_q != CW'(DEPTH));
   assign outValid = (level_q != '0);
   assign push = inValid && inReady;
   assign pop = outReady && outValid;
   assign outData = mem[rdPtr_q];
   assign level = level_q;

   always_ff @(posedge clk) begin
      if (clkEn && push) begin
         mem[wrPtr_q] <= inData;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
         level_q <= '0;
      end else if (clkEn) begin
         if (flush) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            level_q <= '0;
         end else begin
            if (push) begin
               wrPtr_q <= advance(wrPtr_q);
            end
            if (pop) begin
               rdPtr_q <= advance(rdPtr_q);
            end
            if (push && !pop) begin
               level_q <= level_q + 1'b1;
            end else if (pop && !push) begin
               level_q <= level_q - 1'b1;
            end
         end
      end
   end

   // a push refused while full leaves the count alone
   property p_full_hold;
      @(posedge clk) disable iff (!rst_b)
      (clkEn && inValid && !inReady && !outReady && !flush) |=> (level_q == $past(level_q));
   endproperty
   a_full_hold: assert property (p_full_hold) else $error("count moved on refused push"); // RL15
endmodule : byte_fifo

// ==== rtl/strobe_timer.sv ====
// automatic strobe: lead delay then low pulse of programmed clocks
module strobe_timer
   import printer_port_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic clkEn,
   input wire logic start,
   input wire strobe_timing_t timing,
   output logic strobeAct,
   output logic done
);
   strobe_timing_t lat_q;
   logic [4:0] cnt_q;
   logic busy_q;
   logic pulse_q;
   logic [4:0] pulseLen_q;

   assign strobeAct = pulse_q;
   assign done = clkEn && busy_q && pulse_q && (cnt_q == lat_q.width);

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         lat_q <= '0;
         cnt_q <= 5'h1;
         busy_q <= 1'b0;
         pulse_q <= 1'b0;
      end else if (clkEn) begin
         if (start && !busy_q) begin
            lat_q <= timing;
            cnt_q <= 5'h1;
            busy_q <= 1'b1;
         end else if (busy_q && !pulse_q) begin
            if (cnt_q == lat_q.delay) begin // RL2
               pulse_q <= 1'b1;
               cnt_q <= 5'h1;
            end else begin
               cnt_q <= cnt_q + 5'h1;
            end
         end else if (busy_q) begin
            if (cnt_q == lat_q.width) begin // RL2
               pulse_q <= 1'b0;
               busy_q <= 1'b0;
            end else begin
               cnt_q <= cnt_q + 5'h1;
            end
         end
      end
   end

   // helper: length of the current low pulse in enabled clocks
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         pulseLen_q <= '0;
      end else if (clkEn) begin
         pulseLen_q <= pulse_q ? pulseLen_q + 5'h1 : 5'h0;
      end
   end

   sequence s_pulse_end;
      pulse_q ##1 !pulse_q;
   endsequence
   property p_width;
      @(posedge clk) disable iff (!rst_b)
      s_pulse_end |-> ($past(pulseLen_q) + 5'h1 == lat_q.width);
   endproperty
   a_width: assert property (p_width) else $error("strobe width wrong"); // RL2
endmodule : strobe_timer

// ==== sim/printer_model.sv ====
// printer model: takes strobed bytes and answers with an ack pulse or a busy fall
module printer_model (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic strobe_n,
   input wire logic [7:0] data,
   input wire logic stall,
   input wire logic hsBusy,
   output logic ack_n,
   output logic busy
);
   timeunit 1ns;
   timeprecision 100ps;
   logic prevStrobe_q;
   logic pend_q;
   int cnt_q;
   logic [7:0] got[$];
   always @(posedge clk) begin
      prevStrobe_q <= strobe_n;
      if (!rst_b) begin
         ack_n <= 1'b1;
         busy <= 1'b0;
         pend_q <= 1'b0;
         cnt_q <= 0;
      end else begin
         if (prevStrobe_q && !strobe_n) begin
            got.push_back(data);
            busy <= hsBusy;
         end
         if (!prevStrobe_q && strobe_n) pend_q <= 1'b1;
         if (pend_q && !stall) begin
            cnt_q <= cnt_q + 1;
            if (cnt_q == 2) begin
               ack_n <= hsBusy;
               busy <= 1'b0;
            end
            if (cnt_q == 4) begin
               ack_n <= 1'b1;
               pend_q <= 1'b0;
               cnt_q <= 0;
            end
         end
      end
   end
endmodule : printer_model

// ==== sim/tb_top.sv ====
// self-checking bench for the printer port control block
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import printer_port_pkg::*;
   logic clk;
   logic rst_b;
   reg_req_t regReq;
   logic [7:0] regRdData;
   printer_in_t printerIn;
   logic bidirPinMode;
   logic [7:0] portDataOut;
   logic [7:0] portDataOe;
   logic strobe_n;
   logic autoLinefeed_n;
   logic initOut;
   logic printerSelectIn_n;
   logic printerIrq_n;
   logic printerIrqOe;
   logic stall;
   logic hsBusy;
   logic ackN;
   logic busy;
   int n_errors = 0;
   int checks_done = 0;
   assign printerIn = {ackN, busy, 1'b1, 1'b0, 1'b1};
   initial clk = 1'b0;
   always #12.5 clk = ~clk;
   printer_port_fifo_control #(.DEPTH(4)) i_dut (
      .clk(clk), .rst_b(rst_b), .clkEn(1'b1), .regReq(regReq), .regRdData(regRdData),
      .printerIn(printerIn), .bidirPinMode(bidirPinMode), .portDataIn(8'h3C),
      .portDataOut(portDataOut), .portDataOe(portDataOe), .strobe_n(strobe_n),
      .autoLinefeed_n(autoLinefeed_n), .initOut(initOut),
      .printerSelectIn_n(printerSelectIn_n), .printerIrq_n(printerIrq_n),
      .printerIrqOe(printerIrqOe)
   );
   printer_model prn (
      .clk(clk), .rst_b(rst_b), .strobe_n(strobe_n), .data(portDataOut), .stall(stall),
      .hsBusy(hsBusy), .ack_n(ackN), .busy(busy)
   );
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic waitN(input int n);
      repeat (n) @(negedge clk);
   endtask : waitN
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(negedge clk);
      regReq <= '{a, 1'b1, 1'b0, d};
      @(negedge clk);
      regReq.wr <= 1'b0;
   endtask : wr
   task automatic rdChk(input logic [1:0] a, input logic [7:0] exp);
      @(negedge clk);
      regReq <= '{a, 1'b0, 1'b1, 8'h00};
      @(negedge clk);
      regReq.rd <= 1'b0;
      chk(regRdData, exp);
   endtask : rdChk
   task automatic t_reset();
      chk(portDataOut, 8'h00);
      chk(portDataOe, 8'hFF);
      chk({4'h0, strobe_n, autoLinefeed_n, printerSelectIn_n, initOut}, 8'h0E);
      rdChk(2'h3, 8'h80);
   endtask : t_reset
   task automatic t_dir();
      wr(2'h1, 8'hAA);
      chk(portDataOe, 8'h00);
      wr(2'h2, 8'h20);
      chk(portDataOe, 8'h00);
      rdChk(2'h0, 8'h3C);
      wr(2'h1, 8'h55);
      chk(portDataOe, 8'hFF);
      bidirPinMode = 1'b1;
      waitN(1);
      chk(portDataOe, 8'h00);
      wr(2'h1, 8'h55);
      chk(portDataOe, 8'h00);
      wr(2'h2, 8'h00);
      chk(portDataOe, 8'hFF);
      rdChk(2'h1, 8'hEF);
      wr(2'h2, 8'h01);
      chk({7'h0, strobe_n}, 8'h00);
      wr(2'h2, 8'h00);
   endtask : t_dir
   task automatic t_timing();
      int dly[8] = '{3, 5, 5, 9, 6, 10, 10, 18};
      int wid[8] = '{2, 4, 4, 8, 4, 8, 8, 16};
      int t;
      int w;
      logic [7:0] b;
      for (int c = 0; c < 8; c++) begin
         b = 8'hA0 + 8'(c);
         wr(2'h3, 8'h80 | 8'(c));
         wr(2'h0, b);
         t = 0;
         while (strobe_n !== 1'b0 && t < 100) begin
            @(negedge clk);
            t++;
         end
         chk(portDataOut, b);
         w = 0;
         while (strobe_n === 1'b0 && w < 100) begin
            @(negedge clk);
            w++;
         end
         chk(8'(t - 1), 8'(dly[c]));
         chk(8'(w), 8'(wid[c]));
         waitN(12);
         chk(prn.got.pop_back(), b);
      end
      wr(2'h2, 8'h11);
      waitN(30);
      chk({7'h0, strobe_n}, 8'h01);
      chk({7'h0, printerIrqOe}, 8'h01);
   endtask : t_timing
   task automatic t_full();
      stall = 1'b1;
      wr(2'h3, 8'hA0);
      prn.got.delete();
      for (int i = 0; i < 6; i++) wr(2'h0, 8'h10 + 8'(i));
      rdChk(2'h3, 8'h04);
      chk({7'h0, printerIrq_n}, 8'h00);
      wr(2'h3, 8'hE0);
      chk({7'h0, printerIrq_n}, 8'h01);
      wr(2'h3, 8'hB0);
      rdChk(2'h1, 8'h2A);
      chk({7'h0, printerIrq_n}, 8'h01);
      stall = 1'b0;
      waitN(150);
      rdChk(2'h3, 8'h00);
      chk({7'h0, printerIrq_n}, 8'h00);
      for (int i = 0; i < 4; i++) chk(prn.got[i], 8'h10 + 8'(i));
      wr(2'h3, 8'h90);
      chk({7'h0, printerIrq_n}, 8'h00);
      rdChk(2'h1, 8'hEB);
   endtask : t_full
   task automatic t_hs();
      wr(2'h3, 8'h88);
      hsBusy = 1'b1;
      wr(2'h0, 8'h31);
      wr(2'h0, 8'h32);
      waitN(80);
      rdChk(2'h3, 8'h00);
      hsBusy = 1'b0;
      wr(2'h0, 8'h33);
      waitN(80);
      rdChk(2'h3, 8'h01);
      chk({7'h0, printerIrq_n}, 8'h01);
      wr(2'h3, 8'hC8);
      chk({7'h0, printerIrq_n}, 8'h00);
      wr(2'h2, 8'h15);
      chk({7'h0, initOut}, 8'h01);
      rdChk(2'h3, 8'h00);
   endtask : t_hs
   task automatic end_of_test();
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : end_of_test
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      end_of_test();
   end
   initial begin
      regReq = '0;
      bidirPinMode = 1'b0;
      stall = 1'b0;
      hsBusy = 1'b0;
      rst_b = 1'b0;
      waitN(10);
      rst_b = 1'b1;
      t_reset();
      t_dir();
      t_timing();
      t_full();
      t_hs();
      end_of_test();
   end
endmodule : tb_top
